// ---- dv/rtcss_match_tb.sv ----
// self-checking bench for the alarm sub-second match block
// assumes the bench alone drives the design on one 20 mhz clock
`timescale 1ns/100ps
`default_nettype none
`include "rtcss_cfg.svh"
module rtcss_match_tb
    import rtcss_pkg::*;
;
    localparam logic [14:0] VAL = 15'h5A5A;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic        sec_inc = 1'b0;
    logic        fm_a = 1'b0;
    logic        fm_b = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, flag_a, flag_b, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;

    // clock and hang guard
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    // bready and rready held high throughout
    rtcss_match DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .subsecond_counter(cnt),
        .seconds_inc(sec_inc), .fields_match_a(fm_a), .fields_match_b(fm_b),
        .alarm_a_flag(flag_a), .alarm_b_flag(flag_b), .irq(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // handshakes are judged mid-cycle, where they equal the next edge's sample
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_hit, w_hit, b_hit;
        b_hit = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (b_hit !== 1'b1) begin
            @(negedge aclk);
            aw_hit = awvalid & awready;
            w_hit = wvalid & wready;
            b_hit = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end
    endtask : axi_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_hit, r_hit;
        logic [31:0] d;
        logic [1:0]  r;
        r_hit = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (r_hit !== 1'b1) begin
            @(negedge aclk);
            ar_hit = arvalid & arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hit) arvalid <= 1'b0;
        end
        check("rdata", d, exp);
        check("rresp", {30'h0, r}, {30'h0, er});
    endtask : rd_chk

    // one cycle of counter and match inputs, flags seen one edge later
    task automatic pulse(input logic [15:0] c, input logic [2:0] sab, input logic [1:0] ef);
        cnt <= c;
        {sec_inc, fm_a, fm_b} <= sab;
        @(posedge aclk);
        {sec_inc, fm_a, fm_b} <= 3'h0;
        @(negedge aclk);
        check("flags", {30'h0, flag_a, flag_b}, {30'h0, ef});
        @(posedge aclk);
    endtask : pulse

    task automatic chk_irq(input logic e);
        @(negedge aclk);
        check("irq", {31'h0, irq}, {31'h0, e});
        @(posedge aclk);
    endtask : chk_irq

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        logic [1:0]  r;
        logic [14:0] hi;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(`RTCSS_OFF_ALRM_A, 32'h0000_0000, 2'h0);
        rd_chk(`RTCSS_OFF_ALRM_B, 32'h0000_0000, 2'h0);
        pulse({1'b1, ~VAL}, 3'h6, 2'h2);
        rd_chk(8'h60, 32'h0000_0000, 2'h2);
        axi_write(8'h60, 32'hFFFF_FFFF, r);
        check("bresp", {30'h0, r}, 32'h0000_0002);
        axi_write(`RTCSS_OFF_ALRM_A, 32'h0F00_7FFF, r);
        rd_chk(`RTCSS_OFF_ALRM_A, 32'h0F00_7FFF, 2'h0);
        // every compare width: zero fires on the seconds increment only; 1 to 15 match on the low bits, miss on the top one
        for (int n = 0; n < 16; n++) begin
            hi = 15'h7FFF << n;
            axi_write(`RTCSS_OFF_ALRM_A, {4'h0, n[3:0], 9'h000, VAL}, r);
            if (n == 0) begin
                pulse({1'b1, ~VAL}, 3'h6, 2'h2);
                pulse({1'b0, VAL}, 3'h2, 2'h0);
            end else begin
                pulse({1'b1, VAL ^ hi}, 3'h2, 2'h2);
                pulse({1'b0, VAL ^ (15'h0001 << (n - 1))}, 3'h2, 2'h0);
            end
        end
        pulse({1'b0, VAL}, 3'h0, 2'h0);
        // top byte alone: width changes, value kept
        wstrb <= 4'h8;
        axi_write(`RTCSS_OFF_ALRM_A, 32'h0300_0000, r);
        wstrb <= 4'hF;
        rd_chk(`RTCSS_OFF_ALRM_A, 32'h0300_5A5A, 2'h0);
        axi_write(`RTCSS_OFF_ALRM_B, 32'h0F00_1234, r);
        rd_chk(`RTCSS_OFF_ALRM_B, 32'h0F00_1234, 2'h0);
        pulse({1'b0, 15'h1234}, 3'h3, 2'h1);
        pulse({1'b0, 15'h1235}, 3'h1, 2'h0);
        // interrupt masked, unmasked, cleared by status read
        chk_irq(1'b0);
        axi_write(`RTCSS_OFF_MASK, 32'h0000_0003, r);
        chk_irq(1'b1);
        rd_chk(`RTCSS_OFF_STATUS, 32'h0000_0003, 2'h0);
        chk_irq(1'b0);
        axi_write(`RTCSS_OFF_MASK, 32'h0000_0001, r);
        pulse({1'b1, 15'h1234}, 3'h1, 2'h1);
        chk_irq(1'b0);
        rd_chk(`RTCSS_OFF_STATUS, 32'h0000_0002, 2'h0);
        // reset in mid-run clears both alarm registers
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(`RTCSS_OFF_ALRM_A, 32'h0000_0000, 2'h0);
        rd_chk(`RTCSS_OFF_ALRM_B, 32'h0000_0000, 2'h0);
        end_of_test();
    end
endmodule : rtcss_match_tb
`default_nettype wire

// ---- hw/rtcss_cfg.svh ----
// constants for the alarm sub-second match block
// assumes a 32-bit axi4-lite register bus and one clock domain
// Operation
// RQ1: compare width zero skips sub-second compare; fire on seconds increment.
// RQ2: width n of 1..14 compares only the n low bits.
// RQ3: width fifteen compares all fifteen value bits.
// RQ4: counter bit 15 never takes part in any comparison.
// RQ5: stored value compares with counter bits 14 down to 0.
// RQ6: width field in bits 27:24, value in bits 14:0.
// RQ7: software keeps bits 31:28 and 23:15 at zero.
// RQ8: alarm b has its own identical register at its own offset.
// RQ9: both registers clear to zero on reset.
// RQ10: flag only when sub-second match meets other field match.
`ifndef RTCSS_CFG_SVH
`define RTCSS_CFG_SVH
`define RTCSS_OFF_ALRM_A   8'h44
`define RTCSS_OFF_ALRM_B   8'h48
`define RTCSS_OFF_STATUS   8'h4C
`define RTCSS_OFF_MASK     8'h50
`define RTCSS_WID_MSB      27
`define RTCSS_WID_LSB      24
`define RTCSS_VAL_MSB      14
`define RTCSS_RST_VAL      32'h0000_0000
`define RTCSS_WID_FULL     4'hF
`endif

// ---- hw/rtcss_match.sv ----
// alarm a/b sub-second match with axi4-lite registers and interrupt
// assumes counter and match inputs are from logic on the same clock
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rtcss_cfg.svh"
module rtcss_match
    import rtcss_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] subsecond_counter,
    input  wire logic        seconds_inc,
    input  wire logic        fields_match_a,
    input  wire logic        fields_match_b,
    output logic             alarm_a_flag,
    output logic             alarm_b_flag,
    output logic             irq
);
    rtcss_alarm_type alarm_r [2];
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic        aw_have_r;
    logic        w_have_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        flag_a_r;
    logic        flag_b_r;

    // sub-second compare per alarm, bit 15 of the counter dropped
    logic [14:0] cnt15;
    logic [1:0]  ss_hit;
    logic [1:0]  fld_hit;
    logic [1:0]  fire;
    assign cnt15   = subsecond_counter[14:0];  // RQ4 RQ5
    assign fld_hit = {fields_match_b, fields_match_a};
    for (genvar g = 0; g < 2; g++) begin : g_cmp
        logic [14:0] cmp_mask;
        // width n keeps n low bits; 15 keeps all
        assign cmp_mask = (alarm_r[g].width == `RTCSS_WID_FULL) ? 15'h7FFF :  // RQ3
                          15'((16'h0001 << alarm_r[g].width) - 16'h0001);     // RQ2
        // width zero: no compare, fire on the seconds increment
        assign ss_hit[g] = (alarm_r[g].width == 4'h0) ? seconds_inc :       // RQ1
                           (((alarm_r[g].value ^ cnt15) & cmp_mask) == 15'h0000); // RQ5
        assign fire[g] = ss_hit[g] & fld_hit[g];  // RQ10
    end

    // write path: address and data taken in either order
    logic wr_go;
    logic wr_a;
    logic wr_b;
    logic wr_m;
    logic wr_ok;
    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready  = ~w_have_r & ~bvalid_r;
    assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_a  = wr_go & (awaddr_r == `RTCSS_OFF_ALRM_A);  // RQ8
    assign wr_b  = wr_go & (awaddr_r == `RTCSS_OFF_ALRM_B);  // RQ8
    assign wr_m  = wr_go & (awaddr_r == `RTCSS_OFF_MASK);
    assign wr_ok = wr_a | wr_b | wr_m | (awaddr_r == `RTCSS_OFF_STATUS);
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // capture write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // write response, slverr for unmapped addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // alarm registers; only the defined fields are stored
    logic [31:0] wmask;
    logic [31:0] cur_word;
    logic [31:0] new_word;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    // stored word in its read layout, so unstrobed bytes keep their value
    assign cur_word = wr_b ? {4'h0, alarm_r[1].width, 9'h000, alarm_r[1].value}
                           : {4'h0, alarm_r[0].width, 9'h000, alarm_r[0].value};
    // strobed bytes from the bus, the rest from the register
    assign new_word = (wdata_r & wmask) | (cur_word & ~wmask);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_r[0] <= 19'h0_0000;  // RQ9
            alarm_r[1] <= 19'h0_0000;  // RQ9
            mask_r     <= 2'b00;
        end else begin
            // reserved bits of new_word are simply not stored
            if (wr_a) begin
                alarm_r[0] <= {new_word[`RTCSS_WID_MSB:`RTCSS_WID_LSB],
                               new_word[`RTCSS_VAL_MSB:0]};  // RQ6
            end
            if (wr_b) begin
                alarm_r[1] <= {new_word[`RTCSS_WID_MSB:`RTCSS_WID_LSB],
                               new_word[`RTCSS_VAL_MSB:0]};  // RQ6 RQ8
            end
            if (wr_m && wstrb_r[0]) begin
                mask_r <= wdata_r[1:0];
            end
        end
    end

    // read path
    rtcss_rd_type rd_st;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        rd_stat;
    assign rd_stat = (s_axi_araddr == `RTCSS_OFF_STATUS);
    assign rd_hit  = (s_axi_araddr == `RTCSS_OFF_ALRM_A) | (s_axi_araddr == `RTCSS_OFF_ALRM_B)
                   | rd_stat | (s_axi_araddr == `RTCSS_OFF_MASK);
    assign rd_word = (s_axi_araddr == `RTCSS_OFF_ALRM_A) ?
                         {4'h0, alarm_r[0].width, 9'h000, alarm_r[0].value} :  // RQ6
                     (s_axi_araddr == `RTCSS_OFF_ALRM_B) ?
                         {4'h0, alarm_r[1].width, 9'h000, alarm_r[1].value} :
                     rd_stat ? {30'h0000_0000, status_r} :
                     (s_axi_araddr == `RTCSS_OFF_MASK) ? {30'h0000_0000, mask_r} :
                     `RTCSS_RST_VAL;
    assign rd_st = rvalid_r ? RTCSS_RD_RESP : RTCSS_RD_IDLE;
    assign s_axi_arready = (rd_st == RTCSS_RD_IDLE);
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    logic rd_take;
    assign rd_take = s_axi_arvalid & s_axi_arready;

    // read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // sticky status: set on fire, cleared by a status read, set wins
    logic [1:0] status_nxt;
    assign status_nxt = ((rd_take && rd_stat) ? 2'b00 : status_r) | fire;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 2'b00;
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            flag_a_r <= fire[0];  // RQ10
            flag_b_r <= fire[1];  // RQ10
        end
    end
    assign alarm_a_flag = flag_a_r;
    assign alarm_b_flag = flag_b_r;
    assign irq = |(status_r & mask_r);

    // checks
    flag_needs_fields_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_a_flag |-> $past(fields_match_a))
        else $error("alarm a flag without field match");  // RQ10
    width_zero_sec_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'h0 && fields_match_a && seconds_inc) |=> alarm_a_flag)
        else $error("width zero alarm a missed seconds increment");  // RQ1
    width_zero_nosec_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'h0 && !seconds_inc) |=> !alarm_a_flag)
        else $error("width zero alarm a fired without increment");  // RQ1
    low_bit_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'h1 && fields_match_a
         && cnt15[0] == alarm_r[0].value[0]) |=> alarm_a_flag)
        else $error("one-bit compare failed");  // RQ2
    full_match_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[1].width == 4'hF && fields_match_b
         && cnt15 != alarm_r[1].value) |=> !alarm_b_flag)
        else $error("full compare fired on mismatch");  // RQ3
    top_bit_ignored_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[1].width == 4'hF && fields_match_b
         && cnt15 == alarm_r[1].value) |=> alarm_b_flag)
        else $error("full compare missed or used bit 15");  // RQ4 RQ5
    reset_clear_regs: assert property (@(posedge aclk)
        !aresetn |=> alarm_r[0] == 19'h0_0000 && alarm_r[1] == 19'h0_0000)
        else $error("alarm registers not cleared by reset");  // RQ9
    reg_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_a && wstrb_r == 4'hF) |=> alarm_r[0].width == $past(wdata_r[27:24])
                                     && alarm_r[0].value == $past(wdata_r[14:0]))
        else $error("alarm a field layout wrong");  // RQ6
    reg_layout_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_b && wstrb_r == 4'hF) |=> alarm_r[1].value == $past(wdata_r[14:0]))
        else $error("alarm b field layout wrong");  // RQ8
    sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_a_flag |-> status_r[0])
        else $error("alarm a flag without status bit");  // RQ10

    // alarm b mirrors alarm a
    flag_needs_fields_b: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_b_flag |-> $past(fields_match_b))
        else $error("alarm b flag without field match");  // RQ10 RQ8
    width_zero_sec_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[1].width == 4'h0 && fields_match_b && seconds_inc) |=> alarm_b_flag)
        else $error("width zero alarm b missed seconds increment");  // RQ1 RQ8
    width_zero_nosec_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[1].width == 4'h0 && !seconds_inc) |=> !alarm_b_flag)
        else $error("width zero alarm b fired without increment");  // RQ1 RQ8
    low_bit_match_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[1].width == 4'h1 && fields_match_b
         && cnt15[0] == alarm_r[1].value[0]) |=> alarm_b_flag)
        else $error("alarm b one-bit compare failed");  // RQ2 RQ8

    // full width on alarm a, top counter bit left out
    full_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'hF && fields_match_a
         && cnt15 != alarm_r[0].value) |=> !alarm_a_flag)
        else $error("alarm a full compare fired on mismatch");  // RQ3
    top_bit_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'hF && fields_match_a
         && cnt15 == alarm_r[0].value) |=> alarm_a_flag)
        else $error("alarm a full compare missed or used bit 15");  // RQ4 RQ5

    // fourteen-bit compare: bit 14 of the value is a don't-care
    mid_width_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'hE && fields_match_a
         && cnt15[13:0] == alarm_r[0].value[13:0]) |=> alarm_a_flag)
        else $error("alarm a fourteen-bit compare missed");  // RQ2
    mid_width_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alarm_r[0].width == 4'hE && fields_match_a
         && cnt15[13:0] != alarm_r[0].value[13:0]) |=> !alarm_a_flag)
        else $error("alarm a fourteen-bit compare fired on mismatch");  // RQ2

    // byte strobes and register independence
    strobe_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_a && wstrb_r == 4'h8) |=> alarm_r[0].value == $past(alarm_r[0].value)
                                     && alarm_r[0].width == $past(wdata_r[27:24]))
        else $error("alarm a partial write touched wrong field");  // RQ6
    keep_a_on_other: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && !wr_a) |=> alarm_r[0] == $past(alarm_r[0]))
        else $error("alarm a changed by another write");  // RQ8
    keep_b_on_other: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && !wr_b) |=> alarm_r[1] == $past(alarm_r[1]))
        else $error("alarm b changed by another write");  // RQ8

    // bus responses and back-pressure
    wr_slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && !wr_ok) |=> s_axi_bvalid && s_axi_bresp == 2'b10)
        else $error("unmapped write not answered with slverr");
    rd_slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_take && !rd_hit) |=> s_axi_rvalid && s_axi_rresp == 2'b10
                                 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not answered with slverr and zero");
    wr_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
    rd_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data pending");

    // sticky status and mask
    status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_take && rd_stat && fire == 2'b00) |=> status_r == 2'b00)
        else $error("status read did not clear");
    sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!(rd_take && rd_stat) && status_r[0]) |=> status_r[0])
        else $error("alarm a status bit lost without a read");
    mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_m && wstrb_r[0]) |=> mask_r == $past(wdata_r[1:0]))
        else $error("mask write not stored");
    reset_clear_misc: assert property (@(posedge aclk)
        !aresetn |=> status_r == 2'b00 && mask_r == 2'b00 && !bvalid_r && !rvalid_r)
        else $error("status, mask or responses not cleared by reset");

    // main scenarios
    cov_width_zero: cover property (@(posedge aclk) disable iff (!aresetn)
        alarm_r[0].width == 4'h0 && fire[0]);
    cov_fire_a: cover property (@(posedge aclk) disable iff (!aresetn) alarm_a_flag);
    cov_fire_b: cover property (@(posedge aclk) disable iff (!aresetn) alarm_b_flag);
    cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
    cov_stat_rd: cover property (@(posedge aclk) disable iff (!aresetn) rd_take && rd_stat);
endmodule : rtcss_match
`default_nettype wire

// ---- hw/rtcss_pkg.sv ----
// types for the alarm sub-second match block
// assumes rtcss_cfg.svh supplies the numeric constants
package rtcss_pkg;
    typedef struct packed {
        logic [3:0]  width;
        logic [14:0] value;
    } rtcss_alarm_type;
    typedef enum logic [2:0] {
        RTCSS_RD_IDLE = 3'b001,
        RTCSS_RD_RESP = 3'b010,
        RTCSS_RD_HOLD = 3'b100
    } rtcss_rd_type;
endpackage : rtcss_pkg
